// ===== verilog/scp_regs.svh
// Register map, field positions and timing counts of the serial config port.
// Assumes inclusion by both ends and by the bench; definitions only.
`ifndef SCP_REGS_SVH
`define SCP_REGS_SVH
// ********************************
// Device register map
// ********************************
`define SCP_ADR_IFCFG       5'h05
`define SCP_ADR_OFS_A_HI    5'h0C
`define SCP_ADR_OFS_A_LO    5'h0D
`define SCP_ADR_STSEL_OFS_B 5'h0E
`define SCP_ADR_OFS_B_LO    5'h0F
`define SCP_REG_RESET       8'h00
`define SCP_FOUR_WIRE_BIT   7
`define SCP_OFS_SYNC_BIT    5
`define SCP_STSEL_MSB       7
`define SCP_STSEL_LSB       5
// ********************************
// Instruction byte fields
// ********************************
`define SCP_INS_RW_BIT      7
`define SCP_INS_CNT_MSB     6
`define SCP_INS_CNT_LSB     5
`define SCP_INS_ADR_MSB     4
// ********************************
// Controller registers (APB byte addresses)
// ********************************
`define SCP_APB_CTRL        8'h00
`define SCP_APB_TXDATA      8'h04
`define SCP_APB_RXDATA      8'h08
`define SCP_APB_STATUS      8'h0C
`define SCP_APB_INT_STAT    8'h10
`define SCP_APB_INT_MASK    8'h14
// ********************************
// Timing
// ********************************
`define SCP_CLK_PERIOD_NS   8
`define SCP_SCLK_PERIOD_NS  160
`define SCP_SCLK_HALF       ((`SCP_SCLK_PERIOD_NS / `SCP_CLK_PERIOD_NS) / 2)
`endif

// ===== verilog/scp_pkg.sv
// Types shared by both ends of the serial config port.
// Assumes nothing of its surroundings.
package scp_pkg;
    typedef enum logic [1:0] {
        SCP_D_IDLE  = 2'h0,
        SCP_D_INSTR = 2'h1,
        SCP_D_DATA  = 2'h3,
        SCP_D_END   = 2'h2
    } scp_dstate_t;

    typedef enum logic [1:0] {
        SCP_H_IDLE = 2'h0,
        SCP_H_LOW  = 2'h1,
        SCP_H_HIGH = 2'h3,
        SCP_H_END  = 2'h2
    } scp_hstate_t;
endpackage

// ===== verilog/scp_if.sv
// Serial link between the controller and the configuration port.
// Assumes undriven lines float high through an external pull-up.
`timescale 1ns/10ps
interface scp_if;
    logic sclk;
    logic serial_enable_n;
    logic sdio_host_o;
    logic sdio_host_oe_n;
    logic sdio_dev_o;
    logic sdio_dev_oe_n;
    logic serial_data_out_o;
    logic serial_data_out_oe_n;
    logic sdio;
    logic serial_data_out;

    // ********************************
    // Wire resolution
    // ********************************
    assign sdio = !sdio_dev_oe_n ? sdio_dev_o : (!sdio_host_oe_n ? sdio_host_o : 1'b1);
    assign serial_data_out = !serial_data_out_oe_n ? serial_data_out_o : 1'b1;

    modport dev (
        input  sclk, serial_enable_n, sdio,
        output sdio_dev_o, sdio_dev_oe_n, serial_data_out_o, serial_data_out_oe_n
    );
    modport host (
        input  sdio, serial_data_out,
        output sclk, serial_enable_n, sdio_host_o, sdio_host_oe_n
    );
endinterface

// ===== verilog/scp_sync.sv
// Two-flop synchroniser for a bundle of independent levels.
// Assumes each bit may change at any time relative to clk_i.
`timescale 1ns/10ps
module scp_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] q_ff;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_ff <= '0;
            q_ff    <= '0;
        end else begin
            meta_ff <= d_i;
            q_ff    <= meta_ff;
        end
    end

    assign q_o = q_ff;
endmodule

// ===== verilog/scp_dev.sv
// Device end of the serial configuration port with status output mux.
// Assumes the link pins are asynchronous to clk_i and sclk is far slower.
`timescale 1ns/10ps
`include "scp_regs.svh"
module scp_dev import scp_pkg::*; (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    scp_if.dev               lnk,
    input  wire logic [4:0]  status_flags_i,
    output logic      [12:0] offset_a_o,
    output logic      [12:0] offset_b_o,
    output logic             four_wire_select_o
);
    logic [7:0]   regs_ff [32];
    logic [7:0]   nxt_regs [32];
    scp_dstate_t  state_ff, nxt_state;
    logic [2:0]   bitcnt_ff, nxt_bitcnt;
    logic [7:0]   rx_ff, nxt_rx;
    logic [7:0]   tx_ff, nxt_tx;
    logic [4:0]   addr_ff, nxt_addr;
    logic [1:0]   cnt_ff, nxt_cnt;
    logic         rw_ff, nxt_rw;
    logic         drive_ff, nxt_drive;
    logic         out_ff, nxt_out;
    logic         sclk_d_ff;
    logic         sync_d_ff;
    logic [12:0]  ofs_a_ff, nxt_ofs_a;
    logic [12:0]  ofs_b_ff, nxt_ofs_b;
    logic         sdio_o_ff, nxt_sdio_o;
    logic         sdio_oe_n_ff, nxt_sdio_oe_n;
    logic         sdo_o_ff, nxt_sdo_o;
    logic         sdo_oe_n_ff, nxt_sdo_oe_n;
    logic         four_ff;
    logic [7:0]   sync_q;
    logic         sclk_s, sen_s, sdio_s, rise, fall;
    logic [4:0]   flags_s;
    logic [7:0]   byte_in;
    logic [2:0]   st_sel;

    // Status select decode; codes 0, 6 and 7 leave the pin to the port
    function automatic logic st_active(input logic [2:0] sel);
        return (sel >= 3'h1) && (sel <= 3'h5);
    endfunction

    function automatic logic st_bit(input logic [2:0] sel, input logic [4:0] f);
        return f[sel - 3'h1];
    endfunction

    // ********************************
    // Pin synchronisers
    // ********************************
    scp_sync #(.W(8)) u_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   ({lnk.sclk, lnk.serial_enable_n, lnk.sdio, status_flags_i}),
        .q_o   (sync_q)
    );

    assign sclk_s  = sync_q[7];
    assign sen_s   = sync_q[6];
    assign sdio_s  = sync_q[5];
    assign flags_s = sync_q[4:0];
    assign rise    = sclk_s & ~sclk_d_ff;
    assign fall    = ~sclk_s & sclk_d_ff;
    assign byte_in = {rx_ff[6:0], sdio_s};
    assign st_sel  = regs_ff[`SCP_ADR_STSEL_OFS_B][`SCP_STSEL_MSB:`SCP_STSEL_LSB];

    // ********************************
    // Frame engine and register file
    // ********************************
    always_comb begin
        nxt_regs   = regs_ff;
        nxt_state  = state_ff;
        nxt_bitcnt = bitcnt_ff;
        nxt_rx     = rx_ff;
        nxt_tx     = tx_ff;
        nxt_addr   = addr_ff;
        nxt_cnt    = cnt_ff;
        nxt_rw     = rw_ff;
        nxt_drive  = drive_ff;
        nxt_out    = out_ff;
        nxt_ofs_a  = ofs_a_ff;
        nxt_ofs_b  = ofs_b_ff;
        if (sen_s) begin
            nxt_state  = SCP_D_IDLE;
            nxt_bitcnt = 3'h0;
            nxt_drive  = 1'b0;
            nxt_out    = 1'b0;
        end else begin
            if (state_ff == SCP_D_IDLE) begin
                nxt_state = SCP_D_INSTR;
            end
            if (rise) begin
                nxt_rx     = byte_in;
                nxt_bitcnt = bitcnt_ff + 3'h1;
                if (bitcnt_ff == 3'h7) begin
                    case (state_ff)
                        SCP_D_IDLE, SCP_D_INSTR: begin
                            nxt_rw    = byte_in[`SCP_INS_RW_BIT];
                            nxt_cnt   = byte_in[`SCP_INS_CNT_MSB:`SCP_INS_CNT_LSB];
                            nxt_addr  = byte_in[`SCP_INS_ADR_MSB:0];
                            nxt_tx    = regs_ff[byte_in[`SCP_INS_ADR_MSB:0]];
                            nxt_state = SCP_D_DATA;
                        end
                        SCP_D_DATA: begin
                            if (!rw_ff) begin
                                nxt_regs[addr_ff] = byte_in;
                            end
                            if (cnt_ff == 2'h0) begin
                                nxt_state = SCP_D_END;
                                nxt_tx    = 8'h00;
                            end else begin
                                nxt_cnt  = cnt_ff - 2'h1;
                                nxt_addr = addr_ff - 5'h01;
                                nxt_tx   = regs_ff[addr_ff - 5'h01];
                            end
                        end
                        default: begin
                            nxt_state = state_ff;
                        end
                    endcase
                end
            end
            if (fall && rw_ff && (state_ff == SCP_D_DATA || state_ff == SCP_D_END)) begin
                nxt_drive = 1'b1;
                nxt_out   = tx_ff[7];
                nxt_tx    = {tx_ff[6:0], 1'b0};
            end
        end
        if (regs_ff[`SCP_ADR_OFS_A_HI][`SCP_OFS_SYNC_BIT] && !sync_d_ff) begin
            nxt_ofs_a = {regs_ff[`SCP_ADR_OFS_A_HI][4:0], regs_ff[`SCP_ADR_OFS_A_LO]};
            nxt_ofs_b = {regs_ff[`SCP_ADR_STSEL_OFS_B][4:0], regs_ff[`SCP_ADR_OFS_B_LO]};
        end
    end

    // ********************************
    // Pin drivers
    // ********************************
    always_comb begin
        nxt_sdio_o    = nxt_out;
        nxt_sdio_oe_n = !(nxt_drive && !four_ff);
        nxt_sdo_o     = 1'b0;
        nxt_sdo_oe_n  = 1'b1;
        if (st_active(st_sel)) begin
            nxt_sdo_o    = st_bit(st_sel, flags_s);
            nxt_sdo_oe_n = 1'b0;
        end else if (four_ff && nxt_drive) begin
            nxt_sdo_o    = nxt_out;
            nxt_sdo_oe_n = 1'b0;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            for (int i = 0; i < 32; i++) begin
                regs_ff[i] <= `SCP_REG_RESET;
            end
            state_ff     <= SCP_D_IDLE;
            bitcnt_ff    <= 3'h0;
            rx_ff        <= 8'h00;
            tx_ff        <= 8'h00;
            addr_ff      <= 5'h00;
            cnt_ff       <= 2'h0;
            rw_ff        <= 1'b0;
            drive_ff     <= 1'b0;
            out_ff       <= 1'b0;
            sclk_d_ff    <= 1'b0;
            sync_d_ff    <= 1'b0;
            ofs_a_ff     <= 13'h0000;
            ofs_b_ff     <= 13'h0000;
            sdio_o_ff    <= 1'b0;
            sdio_oe_n_ff <= 1'b1;
            sdo_o_ff     <= 1'b0;
            sdo_oe_n_ff  <= 1'b1;
            four_ff      <= 1'b0;
        end else begin
            regs_ff      <= nxt_regs;
            state_ff     <= nxt_state;
            bitcnt_ff    <= nxt_bitcnt;
            rx_ff        <= nxt_rx;
            tx_ff        <= nxt_tx;
            addr_ff      <= nxt_addr;
            cnt_ff       <= nxt_cnt;
            rw_ff        <= nxt_rw;
            drive_ff     <= nxt_drive;
            out_ff       <= nxt_out;
            sclk_d_ff    <= sclk_s;
            sync_d_ff    <= regs_ff[`SCP_ADR_OFS_A_HI][`SCP_OFS_SYNC_BIT];
            ofs_a_ff     <= nxt_ofs_a;
            ofs_b_ff     <= nxt_ofs_b;
            sdio_o_ff    <= nxt_sdio_o;
            sdio_oe_n_ff <= nxt_sdio_oe_n;
            sdo_o_ff     <= nxt_sdo_o;
            sdo_oe_n_ff  <= nxt_sdo_oe_n;
            // Mode only changes with a register write, one cycle after the IFCFG register itself updates
            four_ff      <= regs_ff[`SCP_ADR_IFCFG][`SCP_FOUR_WIRE_BIT];
        end
    end

    assign lnk.sdio_dev_o           = sdio_o_ff;
    assign lnk.sdio_dev_oe_n        = sdio_oe_n_ff;
    assign lnk.serial_data_out_o    = sdo_o_ff;
    assign lnk.serial_data_out_oe_n = sdo_oe_n_ff;
    assign offset_a_o               = ofs_a_ff;
    assign offset_b_o               = ofs_b_ff;
    assign four_wire_select_o       = four_ff;
endmodule

// ===== verilog/scp_host.sv
// Controller end: APB-programmed serial master for the configuration port.
// Assumes the far end answers a falling clock within half a serial period.
`timescale 1ns/10ps
`include "scp_regs.svh"
module scp_host import scp_pkg::*; #(
    parameter int HALF = `SCP_SCLK_HALF
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    output logic             irq_o,
    scp_if.host              lnk
);
    scp_hstate_t  state_ff, nxt_state;
    logic [15:0]  div_ff, nxt_div;
    logic [5:0]   bitcnt_ff, nxt_bitcnt;
    logic [39:0]  sh_ff, nxt_sh;
    logic [31:0]  tx_ff, nxt_tx, rx_ff, nxt_rx, prdata_ff, nxt_prdata;
    logic [9:0]   ctrl_ff, nxt_ctrl;
    logic         ist_ff, nxt_ist, imask_ff, nxt_imask;
    logic         pready_ff, nxt_pready, pslverr_ff, nxt_pslverr, irq_ff;
    logic         sclk_ff, nxt_sclk, sen_n_ff, nxt_sen_n;
    logic         sdio_o_ff, nxt_sdio_o, sdio_oe_n_ff, nxt_sdio_oe_n;
    logic [1:0]   pin_s;
    logic         wr, tick, done, din;
    logic [5:0]   last_bit;

    // ********************************
    // Pin synchronisers
    // ********************************
    scp_sync #(.W(2)) u_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   ({lnk.serial_data_out, lnk.sdio}),
        .q_o   (pin_s)
    );

    // CTRL: [9] four-wire, [8:4] address, [3:2] count, [1] read, [0] start
    assign din      = ctrl_ff[9] ? pin_s[1] : pin_s[0];
    assign wr       = psel_i & penable_i & pready_ff & pwrite_i;
    assign tick     = (div_ff == 16'(HALF - 1));
    assign last_bit = {3'(ctrl_ff[3:2]) + 3'h1, 3'h7};

    always_comb begin
        nxt_pready  = psel_i & ~penable_i & ~pready_ff;
        nxt_pslverr = 1'b0;
        nxt_prdata  = prdata_ff;
        nxt_ctrl    = ctrl_ff;
        nxt_tx      = tx_ff;
        nxt_imask   = imask_ff;
        nxt_state   = state_ff;
        nxt_div     = (state_ff == SCP_H_IDLE || tick) ? 16'h0000 : div_ff + 16'h0001;
        nxt_bitcnt  = bitcnt_ff;
        nxt_sh      = sh_ff;
        nxt_rx      = rx_ff;
        nxt_sclk    = sclk_ff;
        nxt_sen_n   = sen_n_ff;
        nxt_sdio_o  = sdio_o_ff;
        nxt_sdio_oe_n = sdio_oe_n_ff;
        done        = 1'b0;
        // ********************************
        // APB slave
        // ********************************
        if (psel_i && !penable_i) begin
            nxt_prdata = 32'h0000_0000;
            case (paddr_i)
                `SCP_APB_CTRL:     nxt_prdata = {22'h00_0000, ctrl_ff[9:1], 1'b0};
                `SCP_APB_TXDATA:   nxt_prdata = tx_ff;
                `SCP_APB_RXDATA:   nxt_prdata = rx_ff;
                `SCP_APB_STATUS:   nxt_prdata = {31'h0000_0000, state_ff != SCP_H_IDLE};
                `SCP_APB_INT_STAT: nxt_prdata = {31'h0000_0000, ist_ff};
                `SCP_APB_INT_MASK: nxt_prdata = {31'h0000_0000, imask_ff};
                default:           nxt_pslverr = 1'b1;
            endcase
        end
        if (wr && state_ff == SCP_H_IDLE) begin
            // Settings are frozen while a frame runs so it cannot tear
            if (paddr_i == `SCP_APB_CTRL) nxt_ctrl = pwdata_i[9:0];
            if (paddr_i == `SCP_APB_TXDATA) nxt_tx = pwdata_i;
        end
        if (wr && paddr_i == `SCP_APB_INT_MASK) nxt_imask = pwdata_i[0];
        // ********************************
        // Serial engine
        // ********************************
        case (state_ff)
            SCP_H_IDLE: begin
                if (wr && paddr_i == `SCP_APB_CTRL && pwdata_i[0]) begin
                    nxt_sen_n     = 1'b0;
                    nxt_sclk      = 1'b0;
                    nxt_sh        = {pwdata_i[1], pwdata_i[3:2], pwdata_i[8:4], tx_ff};
                    nxt_sdio_o    = pwdata_i[1];
                    nxt_sdio_oe_n = 1'b0;
                    nxt_bitcnt    = 6'h00;
                    nxt_rx        = 32'h0000_0000;
                    nxt_state     = SCP_H_LOW;
                end
            end
            SCP_H_LOW: begin
                if (tick) begin
                    nxt_sclk  = 1'b1;
                    nxt_state = SCP_H_HIGH;
                    if (ctrl_ff[1] && bitcnt_ff >= 6'h08) begin
                        nxt_rx = {rx_ff[30:0], din};
                    end
                end
            end
            SCP_H_HIGH: begin
                if (tick) begin
                    nxt_sclk  = 1'b0;
                    nxt_state = SCP_H_LOW;
                    if (bitcnt_ff == last_bit) begin
                        nxt_sdio_oe_n = 1'b1;
                        nxt_state     = SCP_H_END;
                    end else begin
                        nxt_bitcnt    = bitcnt_ff + 6'h01;
                        nxt_sh        = {sh_ff[38:0], 1'b0};
                        nxt_sdio_o    = sh_ff[38];
                        // Release data pin for read data
                        nxt_sdio_oe_n = ctrl_ff[1] && (bitcnt_ff >= 6'h07);
                    end
                end
            end
            SCP_H_END: begin
                if (tick) begin
                    nxt_sen_n = 1'b1;
                    nxt_state = SCP_H_IDLE;
                    done      = 1'b1;
                end
            end
            default: begin
                nxt_state = SCP_H_IDLE;
            end
        endcase
        // Set wins over a same-cycle clear
        nxt_ist = ist_ff;
        if (wr && paddr_i == `SCP_APB_INT_STAT && pwdata_i[0]) nxt_ist = 1'b0;
        if (done) nxt_ist = 1'b1;
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_ff     <= SCP_H_IDLE;
            div_ff       <= 16'h0000;
            bitcnt_ff    <= 6'h00;
            sh_ff        <= 40'h00_0000_0000;
            tx_ff        <= 32'h0000_0000;
            rx_ff        <= 32'h0000_0000;
            prdata_ff    <= 32'h0000_0000;
            ctrl_ff      <= 10'h000;
            ist_ff       <= 1'b0;
            imask_ff     <= 1'b0;
            pready_ff    <= 1'b0;
            pslverr_ff   <= 1'b0;
            irq_ff       <= 1'b0;
            sclk_ff      <= 1'b0;
            sen_n_ff     <= 1'b1;
            sdio_o_ff    <= 1'b0;
            sdio_oe_n_ff <= 1'b1;
        end else begin
            state_ff     <= nxt_state;
            div_ff       <= nxt_div;
            bitcnt_ff    <= nxt_bitcnt;
            sh_ff        <= nxt_sh;
            tx_ff        <= nxt_tx;
            rx_ff        <= nxt_rx;
            prdata_ff    <= nxt_prdata;
            ctrl_ff      <= nxt_ctrl;
            ist_ff       <= nxt_ist;
            imask_ff     <= nxt_imask;
            pready_ff    <= nxt_pready;
            pslverr_ff   <= nxt_pslverr;
            irq_ff       <= nxt_ist & nxt_imask;
            sclk_ff      <= nxt_sclk;
            sen_n_ff     <= nxt_sen_n;
            sdio_o_ff    <= nxt_sdio_o;
            sdio_oe_n_ff <= nxt_sdio_oe_n;
        end
    end

    assign prdata_o            = prdata_ff;
    assign pready_o            = pready_ff;
    assign pslverr_o           = pslverr_ff;
    assign irq_o               = irq_ff;
    assign lnk.sclk            = sclk_ff;
    assign lnk.serial_enable_n = sen_n_ff;
    assign lnk.sdio_host_o     = sdio_o_ff;
    assign lnk.sdio_host_oe_n  = sdio_oe_n_ff;
endmodule

// ===== sim/scp_properties.sv
// Concurrent checks on the serial link between the controller and the device.
// Assumes the bench instantiates it beside the link interface, clocked by clk_i.
`timescale 1ns/10ps
module scp_properties #(
    parameter int HALF = 10
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic sclk,
    input  wire logic serial_enable_n,
    input  wire logic sdio_host_o,
    input  wire logic sdio_host_oe_n,
    input  wire logic sdio_dev_o,
    input  wire logic sdio_dev_oe_n
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ****************
    // Link timing
    // ****************
    sequence sclk_high_phase;
        $rose(sclk) ##HALF $fell(sclk);
    endsequence
    clock_idle_a: assert property (serial_enable_n |-> !sclk)
        else $error("serial clock moved outside a frame");
    frame_lead_a: assert property ($fell(serial_enable_n) |-> (!sclk)[*6])
        else $error("serial clock rose too soon after frame start");
    sclk_width_a: assert property ($rose(sclk) |-> sclk_high_phase)
        else $error("serial clock high phase has wrong length");
    host_setup_a: assert property ($rose(sclk) && !sdio_host_oe_n |-> $stable(sdio_host_o))
        else $error("host data changed at serial clock rise");
    // ****************
    // Data pin ownership
    // ****************
    pin_clash_a: assert property (!(!sdio_dev_oe_n && !sdio_host_oe_n))
        else $error("both ends drive the data pin");
    dev_start_a: assert property ($fell(sdio_dev_oe_n) |-> sdio_host_oe_n && !serial_enable_n)
        else $error("device drove data pin outside data cycles");
    dev_release_a: assert property ($rose(serial_enable_n) |-> ##[1:8] sdio_dev_oe_n)
        else $error("device kept data pin after frame end");
    dev_hold_a: assert property (sclk && !sdio_dev_oe_n |-> $stable(sdio_dev_o))
        else $error("device read bit changed while serial clock high");
endmodule

// ===== sim/serial_config_port_sdo_mux_test.sv
// Bench driving the controller over APB against the real device end.
// Assumes the design files and scp_regs.svh are compiled first.
`timescale 1ns/10ps
`include "scp_regs.svh"
module serial_config_port_sdo_mux_test;
    logic        clk_i, rst_i, psel, penable, pwrite, pready, pslverr, irq, fw_sel, fw, last_err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, q;
    logic [4:0]  flags;
    logic [12:0] ofs_a, ofs_b;
    int          err_count, num_checks;

    scp_if lnk_if ();
    scp_dev scp_dev_inst (.clk_i(clk_i), .rst_i(rst_i), .lnk(lnk_if.dev), .status_flags_i(flags),
        .offset_a_o(ofs_a), .offset_b_o(ofs_b), .four_wire_select_o(fw_sel));
    scp_host #(.HALF(6)) scp_host_inst (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .irq_o(irq), .lnk(lnk_if.host));
    scp_properties #(.HALF(6)) scp_properties_inst (.clk_i(clk_i), .rst_i(rst_i),
        .sclk(lnk_if.sclk), .serial_enable_n(lnk_if.serial_enable_n),
        .sdio_host_o(lnk_if.sdio_host_o), .sdio_host_oe_n(lnk_if.sdio_host_oe_n),
        .sdio_dev_o(lnk_if.sdio_dev_o), .sdio_dev_oe_n(lnk_if.sdio_dev_oe_n));

    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    // ****************
    // Shared tasks
    // ****************
    task automatic end_sim();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Request held until pready is sampled high, never released early
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready !== 1'b1 && n < 64);
        if (pready !== 1'b1) begin
            err_count++;
            end_sim();
        end
        q = prdata;
        last_err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_i);
    endtask
    // One frame; busy polled with a bound since frames last hundreds of cycles
    task automatic frame(input logic rd, input logic [1:0] c, input logic [4:0] a,
                         input logic [31:0] tx);
        int n;
        apb(1'b1, `SCP_APB_TXDATA, tx);
        apb(1'b1, `SCP_APB_CTRL, 32'({fw, a, c, rd, 1'b1}));
        n = 0;
        do begin
            apb(1'b0, `SCP_APB_STATUS, '0);
            n++;
        end while (q[0] !== 1'b0 && n < 300);
        if (q[0] !== 1'b0) begin
            err_count++;
            end_sim();
        end
    endtask
    // ****************
    // Scenarios
    // ****************
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        fw      = 1'b0;
        paddr   = '0;
        pwdata  = '0;
        flags   = 5'h0D;
        rst_i   = 1'b1;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        frame(1'b1, 2'h1, 5'h0F, '0);
        apb(1'b0, `SCP_APB_RXDATA, '0);
        chk("reset 0F 0E", q, 32'h0000_0000);
        apb(1'b0, `SCP_APB_INT_STAT, '0);
        chk("done flag", q, 32'h0000_0001);
        chk("irq masked", 32'(irq), 32'h0000_0000);
        apb(1'b1, `SCP_APB_INT_MASK, 32'h0000_0001);
        chk("irq on", 32'(irq), 32'h0000_0001);
        apb(1'b1, `SCP_APB_INT_STAT, 32'h0000_0001);
        chk("irq clr", 32'(irq), 32'h0000_0000);
        apb(1'b0, 8'h18, '0);
        chk("unmapped", {q[30:0], last_err}, 32'h0000_0001);
        frame(1'b0, 2'h3, 5'h0F, 32'hA513_3C0A);
        frame(1'b1, 2'h3, 5'h0F, '0);
        apb(1'b0, `SCP_APB_RXDATA, '0);
        chk("burst 4", q, 32'hA513_3C0A);
        chk("staged b", 32'(ofs_b), 32'h0000_0000);
        frame(1'b0, 2'h0, 5'h0C, 32'h2A00_0000);
        chk("offset a", 32'(ofs_a), 32'h0000_0A3C);
        chk("offset b", 32'(ofs_b), 32'h0000_13A5);
        frame(1'b0, 2'h0, 5'h0F, '0);
        chk("no resync", 32'(ofs_b), 32'h0000_13A5);
        frame(1'b0, 2'h0, 5'h05, 32'h8000_0000);
        chk("four wire", 32'(fw_sel), 32'h0000_0001);
        fw = 1'b1;
        frame(1'b1, 2'h0, 5'h0E, '0);
        apb(1'b0, `SCP_APB_RXDATA, '0);
        chk("out pin read", q, 32'h0000_0013);
        // Flags are asynchronous levels, so each is given time to cross
        for (int c = 0; c < 8; c++) begin
            frame(1'b0, 2'h0, 5'h0E, {3'(c), 5'h13, 24'h00_0000});
            repeat (2) begin
                repeat (8) @(posedge clk_i);
                chk("status mux", 32'(lnk_if.serial_data_out),
                    32'((c >= 1 && c <= 5) ? flags[c - 1] : 1'b1));
                flags <= ~flags;
            end
        end
        frame(1'b0, 2'h0, 5'h05, '0);
        chk("three wire", 32'(fw_sel), 32'h0000_0000);
        // Status mux must also work with the port in three-wire mode
        frame(1'b0, 2'h0, 5'h0E, 32'h3300_0000);
        repeat (8) @(posedge clk_i);
        chk("status 3 wire", 32'(lnk_if.serial_data_out), 32'(flags[0]));
        end_sim();
    end
endmodule
